// *** core/port_stat_counter_access.sv ***
// Summary of operation
// - thirty counters per port one to seven
// - indirect read clears the counter
// - index bits 23:16, bit 25 starts read
// - device clears bit 25 when value ready
// - bit 31 reports selected counter overflow
// - bit 24 enables flush and freeze
// - count 35:32 in ctrl, 31:0 in data
//
// The plain strobed port was chosen for this implementation.
module port_stat_counter_access #(
  parameter int NPORTS = 7,
  parameter int NCNT   = 30,
  parameter int CNT_W  = 36
) (
  input  wire logic                            mclk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            ce_i,
  input  wire port_stat_pkg::bus_req_t         bus_i,
  output logic [port_stat_pkg::DATA_W-1:0]     rdata_o,
  input  wire logic [NPORTS-1:0][NCNT-1:0]     cnt_evt_i,
  input  wire logic                            flush_i,
  input  wire logic                            freeze_i,
  output logic                                 irq_o
);
  import port_stat_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                    input int p,
                                    input logic [11:0] ofs);
    port_hit = (a[15:12] == 4'(p + 1)) && (a[11:0] == ofs);
  endfunction

  wire [3:0]  a_port  = bus_i.addr[15:12];
  wire        port_ok = (a_port >= PORT_FIRST) && (a_port <= PORT_LAST);
  wire [2:0]  a_idx   = 3'(a_port - PORT_FIRST);
  wire        is_ctrl = port_ok && (bus_i.addr[11:0] == CTRL_OFS);
  wire        is_low  = port_ok && (bus_i.addr[11:0] == VALUE_LOW_OFS);
  wire        is_stat = bus_i.addr == IRQ_STAT_ADDR;
  wire        is_mask = bus_i.addr == IRQ_MASK_ADDR;

  // ---------------------------------------------------------------
  // per-port indirect access state
  // ---------------------------------------------------------------
  fetch_state_t               st_q     [NPORTS];
  logic                       ff_en_q  [NPORTS];
  logic [IDX_W-1:0]           idx_q    [NPORTS];
  logic [HI_W-1:0]            hi_q     [NPORTS];
  logic [LO_W-1:0]            lo_q     [NPORTS];
  logic                       ovf_cap_q[NPORTS];
  logic [CNT_W-1:0]           cnt_q    [NPORTS][NCNT];
  logic                       ovf_q    [NPORTS][NCNT];

  logic [NPORTS-1:0]          wr_ctrl;
  logic [NPORTS-1:0]          fetch_now;
  logic [NPORTS-1:0]          wrap_any;
  logic [DATA_W-1:0]          ctrl_word[NPORTS];

  genvar gp, gc;
  generate
    for (gp = 0; gp < NPORTS; gp++) begin : g_port
      logic [NCNT-1:0] wrap;
      wire             frz   = freeze_i && ff_en_q[gp];
      wire             flush = flush_i && ff_en_q[gp];
      wire             idx_ok = idx_q[gp] < IDX_W'(NCNT);
      wire [CNT_W-1:0] sel   = idx_ok ? cnt_q[gp][idx_q[gp][4:0]]
                                      : '0;
      wire             sel_ovf = idx_ok && ovf_q[gp][idx_q[gp][4:0]];

      assign wr_ctrl[gp]   = bus_i.wr && port_hit(bus_i.addr, gp, CTRL_OFS);
      assign fetch_now[gp] = st_q[gp] == FETCH_BUSY;
      assign wrap_any[gp]  = |wrap;

      // bit 25 reads one until the value registers hold the fetch
      assign ctrl_word[gp] = {ovf_cap_q[gp],
                              5'h00,
                              fetch_now[gp],
                              ff_en_q[gp],
                              idx_q[gp],
                              12'h000,
                              hi_q[gp]};

      always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          st_q[gp]      <= FETCH_IDLE;
          ff_en_q[gp]   <= 1'b0;
          idx_q[gp]     <= IDX_RST;
          hi_q[gp]      <= HI_RST;
          lo_q[gp]      <= LO_RST;
          ovf_cap_q[gp] <= 1'b0;
        end else if (ce_i) begin
          if (wr_ctrl[gp]) begin
            ff_en_q[gp] <= bus_i.wdata[FF_EN_BIT];
          end
          case (st_q[gp])
            FETCH_IDLE: begin
              if (wr_ctrl[gp]) begin
                idx_q[gp] <= bus_i.wdata[IDX_LSB +: IDX_W];
                if (bus_i.wdata[START_BIT]) begin
                  st_q[gp] <= FETCH_BUSY;
                end
              end
            end
            FETCH_BUSY: begin
              // index held while busy so the fetch stays coherent
              hi_q[gp]      <= sel[CNT_W-1 -: HI_W];
              lo_q[gp]      <= sel[LO_W-1:0];
              ovf_cap_q[gp] <= sel_ovf;
              st_q[gp]      <= FETCH_IDLE;
            end
            default: begin
              st_q[gp] <= FETCH_IDLE;
            end
          endcase
        end
      end

      // thirty independent counters for this port
      for (gc = 0; gc < NCNT; gc++) begin : g_cnt
        wire inc = cnt_evt_i[gp][gc] && !frz;
        // capture and clear share one edge, so the event of that
        // very cycle lands in the fresh count and none is lost
        wire clr = (fetch_now[gp] && idx_ok &&
                    (idx_q[gp][4:0] == 5'(gc))) || flush;
        assign wrap[gc] = inc && !clr && (&cnt_q[gp][gc]);

        always_ff @(posedge mclk_i or negedge rst_n) begin
          if (!rst_n) begin
            cnt_q[gp][gc] <= '0;
            ovf_q[gp][gc] <= 1'b0;
          end else if (ce_i) begin
            if (clr) begin
              cnt_q[gp][gc] <= CNT_W'(inc);
              ovf_q[gp][gc] <= 1'b0;
            end else if (inc) begin
              cnt_q[gp][gc] <= cnt_q[gp][gc] + CNT_W'(1);
              if (wrap[gc]) begin
                ovf_q[gp][gc] <= 1'b1;
              end
            end
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  wire  [IRQ_W-1:0] evt = IRQ_W'({wrap_any, 1'b0, fetch_now});
  wire  [IRQ_W-1:0] w1c = (bus_i.wr && is_stat) ?
                          bus_i.wdata[IRQ_W-1:0] : '0;
  // a new event beats a clear written in the same cycle
  wire  [IRQ_W-1:0] stat_d = (stat_q & ~w1c) | evt;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      irq_o  <= 1'b0;
    end else if (ce_i) begin
      stat_q <= stat_d;
      if (bus_i.wr && is_mask) begin
        mask_q <= bus_i.wdata[IRQ_W-1:0];
      end
      irq_o <= |(stat_d & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] rdata_d =
    !bus_i.rd ? RDATA_RST :
    is_ctrl   ? ctrl_word[a_idx] :
    is_low    ? lo_q[a_idx] :
    is_stat   ? DATA_W'(stat_q) :
    is_mask   ? DATA_W'(mask_q) : RDATA_RST;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= RDATA_RST;
    end else if (ce_i) begin
      rdata_o <= rdata_d;
    end
  end

endmodule

// *** core/port_stat_pkg.sv ***
package port_stat_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // register map: port n sits at n * 0x1000 plus the offsets below
  // ---------------------------------------------------------------
  localparam logic [3:0]  PORT_FIRST    = 4'h1;
  localparam logic [3:0]  PORT_LAST     = 4'h7;
  localparam logic [11:0] CTRL_OFS      = 12'h500;
  localparam logic [11:0] VALUE_LOW_OFS = 12'h504;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'h0f00;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'h0f04;

  // ---------------------------------------------------------------
  // control/status field layout
  // ---------------------------------------------------------------
  localparam int OVF_BIT   = 31;
  localparam int START_BIT = 25;
  localparam int FF_EN_BIT = 24;
  localparam int IDX_LSB   = 16;
  localparam int IDX_W     = 8;
  localparam int HI_LSB    = 0;
  localparam int HI_W      = 4;
  localparam int LO_W      = 32;

  // interrupt status: fetch done per port in [6:0], overflow in [14:8]
  localparam int IRQ_DONE_LSB = 0;
  localparam int IRQ_OVF_LSB  = 8;
  localparam int IRQ_W        = 15;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0]  IDX_RST   = 8'h00;
  localparam logic [HI_W-1:0]   HI_RST    = 4'h0;
  localparam logic [LO_W-1:0]   LO_RST    = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]  IRQ_RST   = 15'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef enum {FETCH_IDLE, FETCH_BUSY} fetch_state_t;

endpackage

// *** bench/port_stat_counter_access_sva.sv ***
module port_stat_counter_access_sva #(
  parameter int NPORTS = 7,
  parameter int NCNT   = 30,
  parameter int CNT_W  = 36
) (
  input wire logic                                mclk_i,
  input wire logic                                reset_n_i,
  input wire logic                                ce_i,
  input wire port_stat_pkg::bus_req_t             bus_i,
  input wire logic [port_stat_pkg::DATA_W-1:0]    rdata_o,
  input wire logic [NPORTS-1:0][NCNT-1:0]         cnt_evt_i,
  input wire logic                                flush_i,
  input wire logic                                freeze_i,
  input wire logic                                irq_o
);
  import port_stat_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // ---------------------------------------------------------------
  // fetch steps, read data, interrupt and reset outputs
  // ---------------------------------------------------------------
  sequence s_start;
    ce_i && bus_i.wr && bus_i.addr[11:0] == CTRL_OFS && bus_i.wdata[START_BIT]
      && bus_i.addr[15:12] inside {[PORT_FIRST:PORT_LAST]};
  endsequence
  sequence s_rd_same;
    bus_i.rd && bus_i.addr == $past(bus_i.addr);
  endsequence
  a_busy_seen: assert property (
    !bus_i.wr ##1 s_start ##1 s_rd_same |=> rdata_o[START_BIT])
    else $error("start bit not shown while busy");
  a_done_seen: assert property (
    s_start ##1 !bus_i.wr ##1 (bus_i.rd && bus_i.addr == $past(bus_i.addr, 2))
    |=> !rdata_o[START_BIT]) else $error("start bit not cleared");
  a_reserved_zero: assert property (
    $past(ce_i && bus_i.rd && bus_i.addr[11:0] == CTRL_OFS)
    |-> rdata_o[30:26] == '0 && rdata_o[15:4] == '0)
    else $error("reserved control bits not zero");
  a_idle_zero: assert property ($past(ce_i && !bus_i.rd) |-> rdata_o == '0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (
    $past(ce_i && bus_i.rd && bus_i.addr[15:12] == 4'h0 &&
      bus_i.addr != IRQ_STAT_ADDR && bus_i.addr != IRQ_MASK_ADDR)
    |-> rdata_o == '0) else $error("port zero region not empty");
  a_stat_width: assert property (
    $past(ce_i && bus_i.rd && bus_i.addr == IRQ_STAT_ADDR)
    |-> rdata_o[31:IRQ_W] == '0) else $error("status upper bits set");
  a_mask_quiet: assert property (
    ce_i && bus_i.wr && bus_i.addr == IRQ_MASK_ADDR && bus_i.wdata == '0
    ##1 !bus_i.wr |=> !irq_o) else $error("interrupt with mask clear");
  a_reset_quiet: assert property ($rose(reset_n_i)
    |-> (rdata_o == '0 && !irq_o) ##1 (rdata_o == '0 && !irq_o))
    else $error("outputs active after reset");
endmodule
bind port_stat_counter_access port_stat_counter_access_sva #(
  .NPORTS(NPORTS), .NCNT(NCNT), .CNT_W(CNT_W)) u_sva (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .cnt_evt_i(cnt_evt_i), .flush_i(flush_i),
  .freeze_i(freeze_i), .irq_o(irq_o));

// *** bench/port_stat_counter_access_test.sv ***
module port_stat_counter_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  import port_stat_pkg::*;
  logic             mclk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  bus_req_t         bus = '0;
  logic [6:0][29:0] evt = '0;
  logic             flush = 1'b0;
  logic             freeze = 1'b0;
  logic             ce = 1'b1;
  logic [31:0]      rdata;
  logic             irq;
  int               n_mismatch = 0;
  int               checked = 0;
  int               cycles = 0;
  port_stat_counter_access uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .ce_i(ce), .bus_i(bus), .rdata_o(rdata), .cnt_evt_i(evt),
    .flush_i(flush), .freeze_i(freeze), .irq_o(irq));
  initial forever #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // ---------------------------------------------------------------
  // bus and event drivers; each ends 1 ns past an edge
  // ---------------------------------------------------------------
  task automatic cyc(input logic w, input logic r, input logic [15:0] a,
                     input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge mclk_i);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    cyc(1'b0, 1'b1, a, '0);
    d = rdata;
  endtask
  task automatic pulse(input int p, input int i, input int n);
    repeat (n) begin
      evt[p-1][i] <= 1'b1;
      @(posedge mclk_i);
      evt[p-1][i] <= 1'b0;
      #1;
    end
  endtask
  // start and read straight after, so the busy view is seen too
  task automatic fetch(input int p, input int i, input logic [35:0] exp,
                       input logic [31:0] base);
    logic [31:0] v;
    bus <= '{addr: {4'(p), CTRL_OFS}, wdata: base | 32'(i) << IDX_LSB |
             32'h1 << START_BIT, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus <= '{addr: {4'(p), CTRL_OFS}, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus <= '0;
    #1 chk(32'(rdata[START_BIT]), 32'h1);
    rd({4'(p), CTRL_OFS}, v);
    chk(v, base | 32'(i) << IDX_LSB | 32'(exp[35:32]));
    rd({4'(p), VALUE_LOW_OFS}, v);
    chk(v, exp[31:0]);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_refuse();
    logic [31:0] v;
    rd(16'h1500, v);
    chk(v, 32'h0);
    cyc(1'b1, 1'b0, 16'h1504, 32'hffff_ffff);
    rd(16'h1504, v);
    chk(v, 32'h0);
    rd(16'h0500, v);
    chk(v, 32'h0);
    rd(IRQ_STAT_ADDR, v);
    chk(v, 32'h0);
  endtask
  task automatic t_ports();
    for (int p = 1; p <= 7; p++) pulse(p, p == 7 ? 29 : (p - 1) * 4, p + 2);
    for (int p = 1; p <= 7; p++) begin
      fetch(p, p == 7 ? 29 : (p - 1) * 4, 36'(p + 2), '0);
      fetch(p, p == 7 ? 29 : (p - 1) * 4, 36'h0, '0);
    end
    fetch(1, 30, 36'h0, '0);
  endtask
  task automatic t_flush_freeze();
    cyc(1'b1, 1'b0, 16'h2500, 32'h1 << FF_EN_BIT);
    pulse(2, 3, 5);
    pulse(3, 3, 5);
    flush <= 1'b1;
    @(posedge mclk_i);
    flush <= 1'b0;
    fetch(2, 3, 36'h0, 32'h1 << FF_EN_BIT);
    fetch(3, 3, 36'h5, '0);
    freeze <= 1'b1;
    pulse(2, 3, 4);
    pulse(3, 3, 4);
    freeze <= 1'b0;
    fetch(2, 3, 36'h0, 32'h1 << FF_EN_BIT);
    fetch(3, 3, 36'h4, '0);
  endtask
  // enable low: events, a start write and counting are all held off
  task automatic t_hold();
    ce <= 1'b0;
    pulse(5, 1, 3);
    cyc(1'b1, 1'b0, 16'h5500, 32'h1 << START_BIT);
    ce <= 1'b1;
    fetch(5, 1, 36'h0, '0);
  endtask
  task automatic t_irq();
    logic [31:0] v;
    cyc(1'b1, 1'b0, IRQ_STAT_ADDR, 32'h7fff);
    cyc(1'b1, 1'b0, IRQ_MASK_ADDR, 32'h1);
    fetch(1, 0, 36'h0, '0);
    chk(32'(irq), 32'h1);
    cyc(1'b1, 1'b0, IRQ_STAT_ADDR, 32'h1);
    rd(IRQ_STAT_ADDR, v);
    chk({v[31:1], irq}, 32'h0);
    cyc(1'b1, 1'b0, IRQ_MASK_ADDR, 32'h0);
    rd(IRQ_STAT_ADDR, v);
    fetch(4, 0, 36'h0, '0);
    rd(IRQ_STAT_ADDR, v);
    chk({v[31:1], irq}, 32'h8);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    t_reset_refuse();
    t_ports();
    t_flush_freeze();
    t_hold();
    t_irq();
    wrap_up();
  end
endmodule
